// ---- include/dcs_pkg.sv ----
// Purpose: shared constants and types for the oscillator control block
// Assumes: one 100 MHz core clock; serial pins sampled as synchronous inputs
// Notes:   command codes, word fields and pipeline depths live here only
package dcs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Serial word layout
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned CNT_BITS      = 4;
  localparam logic [3:0]  LAST_BIT      = 4'hf;
  localparam int unsigned CMD_HI        = 15;
  localparam int unsigned CMD_LO        = 12;
  localparam int unsigned ADDR_HI       = 11;
  localparam int unsigned ADDR_LO       = 8;
  localparam int unsigned BYTE_HI       = 7;
  localparam int unsigned BYTE_LO       = 0;
  localparam int unsigned KIND_HI       = 15;
  localparam int unsigned KIND_LO       = 14;
  localparam int unsigned SYNC_BIT      = 13;
  localparam int unsigned ORIGIN_BIT    = 12;
  localparam int unsigned SLEEP_BIT     = 13;
  localparam int unsigned ACCRST_BIT    = 12;
  localparam int unsigned CLEAR_BIT     = 11;
  localparam int unsigned FBIT_POS      = 11;
  localparam int unsigned PBIT_HI       = 10;
  localparam int unsigned PBIT_LO       = 9;
  // Address bits picking the target register and the frequency half
  localparam int unsigned AREG_HI       = 10;
  localparam int unsigned AREG_LO       = 9;
  localparam int unsigned AHALF_POS     = 9;
  localparam int unsigned AFREG_POS     = 10;

  // Word kinds in the top two bits
  localparam logic [1:0] KIND_SYNC_SRC  = 2'h2;
  localparam logic [1:0] KIND_PWR_CLR   = 2'h3;

  // Data commands
  localparam logic [3:0] CMD_PHASE_16   = 4'h0;
  localparam logic [3:0] CMD_PHASE_8    = 4'h1;
  localparam logic [3:0] CMD_FREQ_16    = 4'h2;
  localparam logic [3:0] CMD_FREQ_8     = 4'h3;
  localparam logic [3:0] CMD_SEL_PHASE  = 4'h4;
  localparam logic [3:0] CMD_SEL_FREQ   = 4'h5;
  localparam logic [3:0] CMD_SEL_BOTH   = 4'h6;

  // Datapath widths
  localparam int unsigned ACC_BITS      = 32;
  localparam int unsigned PHASE_BITS    = 12;
  localparam int unsigned HALF_BITS     = 16;
  localparam int unsigned FREQ_REGS     = 2;
  localparam int unsigned PHASE_REGS    = 4;
  localparam logic [31:0] ACC_ZERO      = 32'h0000_0000;

  // Pipeline depths: load strobe taps and output stages
  localparam int unsigned LOAD_TAPS     = 3;
  localparam int unsigned TAP_BYPASS    = 0;
  localparam int unsigned TAP_SYNC      = 2;
  localparam int unsigned OUT_STAGES    = 2;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_SHIFT = 2'b01,
    SER_WAIT  = 2'b10
  } dcs_ser_state_type;

  typedef struct packed {
    logic       freq;
    logic [1:0] phase;
  } dcs_select_type;

  localparam dcs_select_type SEL_ZERO = '{freq: 1'b0, phase: 2'h0};

endpackage

// ---- logic/dcs_delay_line.sv ----
// Purpose: fixed-depth register chain exposing every tap
// Assumes: synchronous active-high reset
// Notes:   used for the load strobe pipeline and the output stages
`timescale 1ns/1ps
`default_nettype none
module dcs_delay_line #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = 2
) (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  // Data
  input  wire logic [WIDTH-1:0]               din,
  output logic      [STAGES-1:0][WIDTH-1:0]   taps
);

  logic [STAGES-1:0][WIDTH-1:0] chain_reg;
  logic [STAGES-1:0][WIDTH-1:0] chain_next;

  always_comb
  begin
    chain_next = {chain_reg[STAGES-2:0], din};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      chain_reg <= '0;
    else
      chain_reg <= chain_next;
  end

  assign taps = chain_reg;

endmodule // dcs_delay_line
`default_nettype wire

// ---- logic/dcs_control_sync.sv ----
// Purpose: serial command decoder, register loader and select pipeline of an NCO
// Assumes: serial and select pins synchronous to clk_sys; clk_sys is the master clock
// Notes:   frequency and phase word registers hold no reset value on purpose
// How it works
// - Sync on: loaded word is applied only after two extra pipeline stages.
// - Sync on: select pins pass extra sampling stages on the core clock.
// - Sync off: loads and select sampling skip the extra stages.
// - Sync on: a select value is taken only once stable two cycles.
// - Data word: command 15..12, address 11..8, data byte 7..0, MSB first.
// - Top bits 10: bit 13 sets sync enable, bit 12 select origin.
// - Top bits 11: bit 13 sleep, bit 12 accumulator reset, bit 11 clear.
// - Sync off: phase select pin change controls output six cycles later, frequency select seven.
// - Sync on: phase select pin change controls output eight cycles later, frequency select nine.
// - Unsettled select pins may cost one extra cycle of latency.
// - Sync off: write to selected phase register reaches output in six cycles, frequency register in seven.
// - Sync on: write to selected phase register reaches output in eight cycles, frequency register in nine.
// - Accumulator reset holds the phase accumulator at zero.
// - Clear zeroes sync enable and select origin.
// - After clear both stay off until a new sync/origin word arrives.
// - Accumulator reset leaves frequency and phase registers untouched.
// - Output resumes six cycles (sync off) or eight (sync on) after the word releasing accumulator reset is transferred.
// - Phase accumulator is 32 bits, advancing by the selected frequency word.
// - Selected 12-bit phase register is added to the output phase.
// - Two frequency registers, chosen each cycle by the frequency select.
// - Four phase registers, chosen by the two phase select inputs.
// - Origin 0 takes selection from pins, origin 1 from stored bits.
// - Word is transferred after the sixteenth falling serial clock edge.
// - Commands park a byte in defer or write 16 bits to a frequency half or 12 bits to a phase register.
// - Clear is a one-cycle pulse that returns to zero by itself.
`timescale 1ns/1ps
`default_nettype none
module dcs_control_sync (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Serial port
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        frame_sync_n,
  // Select pins
  input  wire logic        freq_choice_input,
  input  wire logic [1:0]  phase_choice_inputs,
  // Output and status
  output logic      [11:0] wave_phase,
  output logic             power_down,
  output logic             acc_held
);

  // Serial receiver
  dcs_pkg::dcs_ser_state_type ser_state_reg, ser_state_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [15:0] word_reg, word_next;
  logic        sclk_prev_reg;
  logic        strobe_reg, strobe_next;
  logic        sclk_fall;

  assign sclk_fall = sclk_prev_reg & ~ser_clk;

  always_comb
  begin
    ser_state_next = ser_state_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    word_next      = word_reg;
    strobe_next    = 1'b0;
    if (frame_sync_n)
    begin
      ser_state_next = dcs_pkg::SER_IDLE;
      bit_cnt_next   = '0;
    end
    else if (ser_state_reg != dcs_pkg::SER_WAIT && sclk_fall)
    begin
      shift_next   = {shift_reg[14:0], ser_data};
      bit_cnt_next = bit_cnt_reg + 4'h1;
      ser_state_next = dcs_pkg::SER_SHIFT;
      if (bit_cnt_reg == dcs_pkg::LAST_BIT)
      begin
        word_next      = {shift_reg[14:0], ser_data};
        strobe_next    = 1'b1;
        ser_state_next = dcs_pkg::SER_WAIT;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ser_state_reg <= dcs_pkg::SER_IDLE;
      bit_cnt_reg   <= '0;
      shift_reg     <= '0;
      word_reg      <= '0;
      sclk_prev_reg <= 1'b0;
      strobe_reg    <= 1'b0;
    end
    else
    begin
      ser_state_reg <= ser_state_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      word_reg      <= word_next;
      sclk_prev_reg <= ser_clk;
      strobe_reg    <= strobe_next;
    end
  end

  // Load strobe pipeline
  logic [2:0][0:0] load_taps;
  logic            sync_en_reg;
  logic            apply;

  dcs_delay_line #(.WIDTH(1), .STAGES(dcs_pkg::LOAD_TAPS)) u_load_pipe (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (strobe_reg),
    .taps    (load_taps)
  );

  assign apply = sync_en_reg ? load_taps[dcs_pkg::TAP_SYNC][0]
                             : load_taps[dcs_pkg::TAP_BYPASS][0];

  // Command decode and register file
  logic [3:0]  cmd;
  logic [3:0]  addr;
  logic [7:0]  data_byte;
  logic [15:0] joined;

  assign cmd       = word_reg[dcs_pkg::CMD_HI:dcs_pkg::CMD_LO];
  assign addr      = word_reg[dcs_pkg::ADDR_HI:dcs_pkg::ADDR_LO];
  assign data_byte = word_reg[dcs_pkg::BYTE_HI:dcs_pkg::BYTE_LO];

  logic [7:0]  defer_reg, defer_next;
  logic        origin_reg, origin_next;
  logic        sync_en_next;
  logic        sleep_reg, sleep_next;
  logic        accrst_reg, accrst_next;
  logic        clear_reg, clear_next;
  dcs_pkg::dcs_select_type bit_sel_reg, bit_sel_next;
  logic [1:0][31:0] freq_word_reg, freq_word_next;
  logic [3:0][11:0] phase_word_reg, phase_word_next;

  assign joined = {data_byte, defer_reg};

  always_comb
  begin
    defer_next      = defer_reg;
    origin_next     = origin_reg;
    sync_en_next    = sync_en_reg;
    sleep_next      = sleep_reg;
    accrst_next     = accrst_reg;
    clear_next      = 1'b0;
    bit_sel_next    = bit_sel_reg;
    freq_word_next  = freq_word_reg;
    phase_word_next = phase_word_reg;
    if (clear_reg)
    begin
      sync_en_next = 1'b0;
      origin_next  = 1'b0;
    end
    if (apply)
    begin
      if (word_reg[dcs_pkg::KIND_HI:dcs_pkg::KIND_LO] == dcs_pkg::KIND_PWR_CLR)
      begin
        sleep_next  = word_reg[dcs_pkg::SLEEP_BIT];
        accrst_next = word_reg[dcs_pkg::ACCRST_BIT];
        clear_next  = word_reg[dcs_pkg::CLEAR_BIT];
      end
      else if (word_reg[dcs_pkg::KIND_HI:dcs_pkg::KIND_LO] == dcs_pkg::KIND_SYNC_SRC)
      begin
        sync_en_next = word_reg[dcs_pkg::SYNC_BIT];
        origin_next  = word_reg[dcs_pkg::ORIGIN_BIT];
      end
      else if (cmd == dcs_pkg::CMD_PHASE_8 || cmd == dcs_pkg::CMD_FREQ_8)
        defer_next = data_byte;
      else if (cmd == dcs_pkg::CMD_PHASE_16)
        phase_word_next[addr[dcs_pkg::AREG_HI-dcs_pkg::ADDR_LO:dcs_pkg::AREG_LO-dcs_pkg::ADDR_LO]]
          = joined[11:0];
      else if (cmd == dcs_pkg::CMD_FREQ_16)
      begin
        if (addr[dcs_pkg::AHALF_POS-dcs_pkg::ADDR_LO])
          freq_word_next[addr[dcs_pkg::AFREG_POS-dcs_pkg::ADDR_LO]][31:16] = joined;
        else
          freq_word_next[addr[dcs_pkg::AFREG_POS-dcs_pkg::ADDR_LO]][15:0] = joined;
      end
      else if (cmd == dcs_pkg::CMD_SEL_PHASE || cmd == dcs_pkg::CMD_SEL_BOTH)
      begin
        bit_sel_next.phase = word_reg[dcs_pkg::PBIT_HI:dcs_pkg::PBIT_LO];
        if (cmd == dcs_pkg::CMD_SEL_BOTH)
          bit_sel_next.freq = word_reg[dcs_pkg::FBIT_POS];
      end
      else if (cmd == dcs_pkg::CMD_SEL_FREQ)
        bit_sel_next.freq = word_reg[dcs_pkg::FBIT_POS];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      defer_reg   <= '0;
      origin_reg  <= 1'b0;
      sync_en_reg <= 1'b0;
      sleep_reg   <= 1'b0;
      accrst_reg  <= 1'b1;
      clear_reg   <= 1'b0;
      bit_sel_reg <= dcs_pkg::SEL_ZERO;
    end
    else
    begin
      defer_reg   <= defer_next;
      origin_reg  <= origin_next;
      sync_en_reg <= sync_en_next;
      sleep_reg   <= sleep_next;
      accrst_reg  <= accrst_next;
      clear_reg   <= clear_next;
      bit_sel_reg <= bit_sel_next;
    end
  end

  // Word registers keep their contents across every reset
  always_ff @(posedge clk_sys)
  begin
    freq_word_reg  <= freq_word_next;
    phase_word_reg <= phase_word_next;
  end

  // Select path and accumulator
  dcs_pkg::dcs_select_type pins, pin_s1_reg, pin_s2_reg, pin_s3_reg;
  dcs_pkg::dcs_select_type sel_reg, sel_next;
  logic [31:0] freq_now_reg, freq_now_next;
  logic [11:0] phase_now_reg, phase_now_next;
  logic [31:0] acc_reg, acc_next;
  logic [11:0] sum_reg, sum_next;
  logic [1:0][11:0] out_taps;

  assign pins = '{freq: freq_choice_input, phase: phase_choice_inputs};

  always_comb
  begin
    sel_next = sel_reg;
    if (origin_reg)
      sel_next = bit_sel_reg;
    else if (!sync_en_reg)
      sel_next = pin_s1_reg;
    else if (pin_s2_reg == pin_s3_reg)
      sel_next = pin_s3_reg;
    freq_now_next  = freq_word_reg[sel_reg.freq];
    phase_now_next = phase_word_reg[sel_reg.phase];
    if (accrst_reg)
      acc_next = dcs_pkg::ACC_ZERO;
    else if (sleep_reg)
      acc_next = acc_reg;
    else
      acc_next = acc_reg + freq_now_reg;
    sum_next = acc_reg[31:20] + phase_now_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_s1_reg    <= dcs_pkg::SEL_ZERO;
      pin_s2_reg    <= dcs_pkg::SEL_ZERO;
      pin_s3_reg    <= dcs_pkg::SEL_ZERO;
      sel_reg       <= dcs_pkg::SEL_ZERO;
      freq_now_reg  <= '0;
      phase_now_reg <= '0;
      acc_reg       <= dcs_pkg::ACC_ZERO;
      sum_reg       <= '0;
    end
    else
    begin
      pin_s1_reg    <= pins;
      pin_s2_reg    <= pin_s1_reg;
      pin_s3_reg    <= pin_s2_reg;
      sel_reg       <= sel_next;
      freq_now_reg  <= freq_now_next;
      phase_now_reg <= phase_now_next;
      acc_reg       <= acc_next;
      sum_reg       <= sum_next;
    end
  end

  dcs_delay_line #(.WIDTH(12), .STAGES(dcs_pkg::OUT_STAGES)) u_out_pipe (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (sum_reg),
    .taps    (out_taps)
  );

  assign wave_phase = out_taps[dcs_pkg::OUT_STAGES-1];
  assign power_down = sleep_reg;
  assign acc_held   = accrst_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_load_bypass: assert property (strobe_reg && !sync_en_reg && cmd == dcs_pkg::CMD_FREQ_8
      |-> ##2 defer_reg == $past(data_byte, 2))
    else $error("bypass defer load not seen two cycles after strobe");
  a_load_synced: assert property (strobe_reg && sync_en_reg && cmd == dcs_pkg::CMD_PHASE_8
      |-> ##4 defer_reg == $past(data_byte, 4) ##0 $past(defer_reg) == $past(defer_reg, 3))
    else $error("synced defer load not four cycles after strobe");
  a_clear_flags: assert property (clear_reg && !apply |=> !sync_en_reg && !origin_reg)
    else $error("clear did not drop sync and origin");
  a_clear_pulse: assert property (clear_reg |=> !clear_reg)
    else $error("clear stayed high");
  a_acc_reset: assert property (accrst_reg |=> acc_reg == dcs_pkg::ACC_ZERO)
    else $error("accumulator not held at zero");
  a_acc_step: assert property (!accrst_reg && !sleep_reg
      |=> acc_reg == $past(acc_reg) + $past(freq_now_reg))
    else $error("accumulator step wrong");
  a_pin_bypass: assert property ((!sync_en_reg && !origin_reg)[*2]
      |-> sel_reg == $past(pins, 2))
    else $error("pin select latency wrong with sync off");
  a_pin_synced: assert property ((sync_en_reg && !origin_reg && $stable(pins))[*4]
      |-> sel_reg == $past(pins, 4))
    else $error("pin select latency wrong with sync on");
  a_bit_origin: assert property (origin_reg |=> sel_reg == $past(bit_sel_reg))
    else $error("stored select bits not used");
  a_word_frame: assert property (strobe_reg |-> ser_state_reg == dcs_pkg::SER_WAIT)
    else $error("word strobe outside a completed frame");

  c_sync_word: cover property (apply && sync_en_reg);
  c_clear_seen: cover property (clear_reg);
  c_freq_write: cover property (apply && cmd == dcs_pkg::CMD_FREQ_16);
  c_acc_run: cover property ($fell(accrst_reg));

endmodule // dcs_control_sync
`default_nettype wire

// ---- verif/dcs_host_model.sv ----
// Purpose: host side of the serial link, shifting one 16-bit word per request
// Assumes: start is pulsed for one cycle while busy is low
// Notes:   slow stretches every serial clock phase from 2 to 4 core cycles
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Request
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [15:0] word,
  output logic             busy,
  // Serial pins
  output logic             ser_clk,
  output logic             ser_data,
  output logic             frame_sync_n
);
  logic [15:0] shift_reg;
  logic [5:0]  edge_cnt;
  logic [1:0]  tick;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy         <= 1'b0;
      ser_clk      <= 1'b1;
      ser_data     <= 1'b0;
      frame_sync_n <= 1'b1;
    end
    else if (!busy && start)
    begin
      // Frame opens with the first bit already on the line
      busy         <= 1'b1;
      frame_sync_n <= 1'b0;
      ser_data     <= word[15];
      shift_reg    <= word;
      edge_cnt     <= 6'h00;
      tick         <= 2'h0;
    end
    else if (busy)
    begin
      if (tick != (slow ? 2'h3 : 2'h1))
        tick <= tick + 2'h1;
      else
      begin
        tick     <= 2'h0;
        edge_cnt <= edge_cnt + 6'h01;
        if (edge_cnt == 6'h20)
        begin
          // Clock parks high after the sixteenth fall
          busy         <= 1'b0;
          frame_sync_n <= 1'b1;
        end
        else if (!edge_cnt[0])
        begin
          ser_clk   <= 1'b0;
          shift_reg <= {shift_reg[14:0], 1'b0};
        end
        else
        begin
          ser_clk  <= 1'b1;
          ser_data <= shift_reg[15];
        end
      end
    end
    else
      ser_data <= ~ser_data;  // Data line is not held outside frames
  end
endmodule  // dcs_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the oscillator control block
// Assumes: host model drives the serial pins; select pins driven here
// Notes:   accumulator held at zero during phase checks, so output equals the phase word
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys;
  logic        sys_rst;
  logic        ser_clk;
  logic        ser_data;
  logic        frame_sync_n;
  logic        freq_choice_input;
  logic [1:0]  phase_choice_inputs;
  logic [11:0] wave_phase;
  logic        power_down;
  logic        acc_held;
  logic        start;
  logic        slow;
  logic        busy;
  logic [15:0] word;
  logic [11:0] phase_m [4];
  logic        origin_m;
  logic [2:0]  bits_m;
  logic [11:0] prev_w;
  logic [31:0] rnd;
  integer      err_count;
  integer      total_checks;
  integer      seed;
  integer      i;

  dcs_control_sync dcs_control_sync_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .frame_sync_n(frame_sync_n), .freq_choice_input(freq_choice_input),
    .phase_choice_inputs(phase_choice_inputs), .wave_phase(wave_phase),
    .power_down(power_down), .acc_held(acc_held));

  dcs_host_model dcs_host_model_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .start(start), .slow(slow), .word(word),
    .busy(busy), .ser_clk(ser_clk), .ser_data(ser_data), .frame_sync_n(frame_sync_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] exp_phase();
    return phase_m[origin_m ? bits_m[1:0] : phase_choice_inputs];
  endfunction

  // One frame, then time for the slowest load path to reach the output
  task automatic send(input logic [15:0] w);
    integer n;
    @(posedge clk_sys);
    word  <= w;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    for (n = 0; n < 300 && busy === 1'b1; n++)
      @(posedge clk_sys);
    repeat (14) @(posedge clk_sys);
    #1;
  endtask

  task automatic load_phase(input logic [1:0] k, input logic [11:0] v);
    send({4'h1, 1'b0, k, 1'b0, v[7:0]});
    send({4'h0, 1'b0, k, 1'b0, 4'h0, v[11:8]});
    phase_m[k] = v;
  endtask

  task automatic load_freq(input logic k, input logic [31:0] v);
    send({4'h3, 1'b0, k, 1'b0, 1'b0, v[7:0]});
    send({4'h2, 1'b0, k, 1'b0, 1'b0, v[15:8]});
    send({4'h3, 1'b0, k, 1'b1, 1'b0, v[23:16]});
    send({4'h2, 1'b0, k, 1'b1, 1'b0, v[31:24]});
  endtask

  // Old value one edge before the latency, new value one edge after it
  task automatic pin_step(input logic [1:0] k, input integer lat);
    logic [11:0] old_v;
    old_v = exp_phase();
    @(posedge clk_sys);
    phase_choice_inputs <= k;
    repeat (lat - 1) @(posedge clk_sys);
    #1 check("phase before latency", old_v, wave_phase);
    repeat (2) @(posedge clk_sys);
    #1 check("phase after latency", exp_phase(), wave_phase);
  endtask

  task automatic check_rate(input logic [11:0] step);
    repeat (12) @(posedge clk_sys);
    #1 prev_w = wave_phase;
    repeat (3)
    begin
      @(posedge clk_sys);
      #1 check("phase step", step, wave_phase - prev_w);
      prev_w = wave_phase;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    seed = 84979;
    err_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    word = 16'h0000;
    freq_choice_input = 1'b0;
    phase_choice_inputs = 2'h0;
    origin_m = 1'b0;
    bits_m = 3'h0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1 check("acc_held", 12'h001, {11'h000, acc_held});
    check("power_down", 12'h000, {11'h000, power_down});
    check("wave_phase", 12'h000, wave_phase);
    send(16'hd000);
    for (i = 0; i < 4; i++)
    begin
      slow <= i[0];
      rnd = $random(seed);
      load_phase(i[1:0], rnd[11:0]);
    end
    check("held phase", exp_phase(), wave_phase);
    $display("test phase loads done");
    for (i = 1; i < 5; i++)
      pin_step(i[1:0], 6);
    send(16'ha000);
    for (i = 1; i < 5; i++)
      pin_step(i[1:0], 8);
    rnd = $random(seed);
    load_phase(2'h0, rnd[11:0]);
    check("sync load", exp_phase(), wave_phase);
    $display("test select latency done");
    send(16'hb000);
    origin_m = 1'b1;
    for (i = 4; i < 8; i++)
    begin
      rnd = $random(seed);
      send({i[3:0], rnd[2:0], 9'h000});
      if (i == 4 || i == 6)
        bits_m[1:0] = rnd[1:0];
      if (i == 5 || i == 6)
        bits_m[2] = rnd[2];
      @(posedge clk_sys);
      phase_choice_inputs <= rnd[4:3];
      repeat (10) @(posedge clk_sys);
      #1 check("bit select", exp_phase(), wave_phase);
    end
    send(16'hd800);
    origin_m = 1'b0;
    check("after clear", exp_phase(), wave_phase);
    pin_step(phase_choice_inputs + 2'h1, 6);
    send(16'h9000);
    origin_m = 1'b1;
    check("origin after clear", exp_phase(), wave_phase);
    $display("test select origin done");
    send(16'hf000);
    check("power_down", 12'h001, {11'h000, power_down});
    send(16'hd000);
    check("power_down", 12'h000, {11'h000, power_down});
    $display("test sleep done");
    load_freq(1'b0, 32'h0010_0000);
    load_freq(1'b1, 32'h0020_0000);
    send(16'h8000);
    origin_m = 1'b0;
    @(posedge clk_sys);
    freq_choice_input <= 1'b0;
    send(16'hc000);
    check("acc_held", 12'h000, {11'h000, acc_held});
    check_rate(12'h001);
    @(posedge clk_sys);
    freq_choice_input <= 1'b1;
    check_rate(12'h002);
    send(16'hd000);
    check("reheld phase", exp_phase(), wave_phase);
    $display("test frequency done");
    print_verdict();
  end

  initial
  begin
    #400000;
    err_count++;
    $display("FAIL watchdog expected finish seen hang");
    print_verdict();
  end
endmodule  // testbench
`default_nettype wire
